// ---- hdl/baa_pkg.sv ----
// Constants shared by the bearing average accumulator.
// Assumes a single 50 MHz system clock and an APB master for the registers.
package baa_pkg;
    localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Control: bit 0 accumulate enable.
    localparam logic [7:0] ADDR_STATUS = 8'h04;  // Status: sampled lines, pulse count.
    localparam logic [7:0] ADDR_WORD   = 8'h08;  // Last angle word driven out.
    localparam logic       CTRL_RESET  = 1'b1;
    localparam logic [1:0] MS_ADDRESS  = 2'h1;   // Fixed decoder address in Mode S.
    localparam logic [5:0] MS_BITS     = 6'h20;  // Message bits that are sampled.
    localparam logic [6:0] MS_COUNT    = 7'h20;  // Count reported for Mode S.
    localparam int         NUM_DEC     = 4;
    localparam int         CNT_W       = 7;
    localparam int         PH_SEN1     = 0;      // Pipeline index of each phase.
    localparam int         PH_SEN2     = 1;
    localparam int         PH_FOURTH   = 2;
    localparam int         PH_MULT     = 3;
    localparam int         PH_SIXTH    = 5;
    localparam int         PH_SEVENTH  = 6;
    localparam int         WORD_VALID  = 15;     // Field positions of the angle word.
    localparam int         WORD_CNT_LO = 8;
endpackage : baa_pkg

// ---- hdl/baa_accumulator.sv ----
// Bearing average accumulator: Mode S sample control, four-decoder sum and count,
// zero-crossing correction, averaging and the two-stage output buffer.
// Assumes the external sampling controller spaces sample enables four clocks apart.
`timescale 1ns/100ps
module baa_accumulator
    import baa_pkg::*;
(
    input  wire logic        clock_in,                // 50 MHz system clock
    input  wire logic        rst_in,                  // Asynchronous reset, active high
    input  wire logic        protocol_select_in,      // 1 selects Mode S processing
    input  wire logic        first_chip_strobe_in,    // Mode S chip-one strobe
    input  wire logic        second_chip_strobe_in,   // Mode S chip-two strobe
    input  wire logic        mode_s_data_in,          // 1 means pulse in chip two
    input  wire logic        preamble_detect_in,      // Mode S preamble found
    input  wire logic        confidence_strobe_in,    // Follows each Mode S data bit
    input  wire logic        atc_sample_enable_in,    // ATCRBS controller sample enable
    input  wire logic        atc_strobe_in,           // ATCRBS controller sample strobe
    input  wire logic [1:0]  atc_decoder_address_in,  // ATCRBS controller decoder address
    input  wire logic [7:0]  angle_sample_in,         // Digitised bearing sample
    input  wire logic [3:0]  bracket_detect_in,       // Per-decoder bracket detection
    input  wire logic [3:0]  reply_done_flag_in,      // Per-decoder reply finished
    input  wire logic [1:0]  write_location_in,       // Reply buffer write location
    input  wire logic [1:0]  read_location_in,        // Reply buffer read location
    input  wire logic        buffer_write_strobe_in,  // Reply buffer write strobe
    input  wire logic        angle_read_request_in,   // ATCRBS angle word request
    input  wire logic        mode_s_angle_request_in, // Mode S angle word request
    input  wire logic        psel_in,                 // APB select
    input  wire logic        penable_in,              // APB enable
    input  wire logic        pwrite_in,               // APB direction
    input  wire logic [7:0]  paddr_in,                // APB byte address
    input  wire logic [31:0] pwdata_in,               // APB write data
    output logic      [31:0] prdata_out,              // APB read data
    output logic             pready_out,              // APB ready
    output logic             pslverr_out,             // APB error, unmapped address
    output logic      [15:0] word_out,                // Angle word bus
    output logic             ms_drive_enable_out,     // Mode S outputs driven
    output logic             sample_process_enable_out, // Mode S sample enable
    output logic             sample_strobe_out,       // Mode S sample strobe
    output logic      [1:0]  decoder_address_out,     // Mode S decoder address
    output logic             two_cycle_clock_out,     // Two-cycle arithmetic clock
    output logic             half_select_out,         // 1 in second half-cycle
    output logic             first_pulse_flag_out,    // Current sample is the first
    output logic      [3:0]  decoder_sampled_line_out // Per-decoder sampled status
);
    import baa_pkg::*;

    typedef struct packed {
        logic                          enable;
        logic [5:0]                    ms_count;
        logic                          ms_sen;
        logic                          ms_stb;
        logic                          ms_drive;
        logic [1:0]                    ms_da;
        logic [7:0]                    raw;
        logic [15:0]                   theta;
        logic                          fp;
        logic [6:0]                    pipe;
        logic [6:0][1:0]               dap;
        logic [NUM_DEC-1:0][CNT_W-1:0] count;
        logic [NUM_DEC-1:0][15:0]      sum;
        logic [NUM_DEC-1:0][1:0]       quad;
        logic [NUM_DEC-1:0]            status;
        logic [CNT_W-1:0]              nlat;
        logic [15:0]                   msum;
        logic [16:0]                   mrec;
        logic [7:0]                    avg;
        logic [NUM_DEC-1:0][14:0]      buf1;
        logic [3:0][15:0]              buf2;
        logic [15:0]                   word;
        logic                          bc;
        logic                          half;
        logic [31:0]                   rdata;
        logic                          ready;
        logic                          err;
    } baa_state_type;

    baa_state_type st;
    baa_state_type next_st;
    logic [16:0]   recip_rom [2**CNT_W];

    // A table trades area for a one-cycle reciprocal; seven count bits cover
    // every count that a Mode S reply or an ATCRBS reply can reach.
    // The reciprocal table is constant; entry zero is never addressed.
    for (genvar i = 0; i < 2**CNT_W; i++) begin : g_recip
        assign recip_rom[i] = 17'(65536 / ((i == 0) ? 1 : i));
    end

    always_comb begin
        logic             sample_process_enable;
        logic             strobe;
        logic [1:0]       da;
        logic [1:0]       d;
        logic [1:0]       id;
        logic [15:0]      th;
        logic signed [32:0] prod;
        logic             setup;
        next_st = st;
        sample_process_enable = 1'b0;
        strobe = 1'b0;
        da = 2'h0;
        d = 2'h0;
        id = 2'h0;
        th = 16'h0000;
        prod = 33'sh0;
        setup = psel_in && !penable_in;

        // Mode S sample control; outputs stay low in ATCRBS mode.
        // The bit count saturates, so a long message cannot wrap it back into
        // the sampled range and admit late bearing samples.
        next_st.ms_drive = protocol_select_in;
        if (preamble_detect_in) begin
            next_st.ms_count = 6'h00;
        end else if (confidence_strobe_in && st.ms_count < MS_BITS) begin
            next_st.ms_count = st.ms_count + 6'h01;
        end
        next_st.ms_stb = protocol_select_in && (st.ms_count < MS_BITS)
            && (mode_s_data_in ? second_chip_strobe_in : first_chip_strobe_in);
        next_st.ms_sen = protocol_select_in && st.ms_stb;
        next_st.ms_da = protocol_select_in ? MS_ADDRESS : 2'h0;

        sample_process_enable = st.enable && (protocol_select_in ? st.ms_sen : atc_sample_enable_in);
        strobe = protocol_select_in ? st.ms_stb : atc_strobe_in;
        da = protocol_select_in ? st.ms_da : atc_decoder_address_in;
        if (strobe) begin
            next_st.raw = angle_sample_in;
        end

        // Sample cycle: first pulse flag and zero-crossing correction.
        // The phase pipeline carries each enable and its address down the stages,
        // so every stage acts on the decoder that its sample was started for.
        next_st.pipe = {st.pipe[5:0], sample_process_enable};
        next_st.dap = {st.dap[5:0], da};
        if (sample_process_enable) begin
            next_st.fp = !st.status[da];
            th = {8'h00, st.raw};
            if (!st.status[da]) begin
                next_st.quad[da] = st.raw[7:6];
            end else if (st.quad[da] == 2'h3 && st.raw[7:6] == 2'h0) begin
                th[8] = 1'b1;
            end else if (st.quad[da] == 2'h0 && st.raw[7:6] == 2'h3) begin
                th[15:8] = 8'hff;
            end
            next_st.theta = th;
        end

        // First half-cycle: count update and, on the same clock, latch for the reciprocal.
        d = st.dap[PH_SEN1];
        if (st.pipe[PH_SEN1]) begin
            next_st.count[d] = st.fp ? 7'h01 : st.count[d] + 7'h01;
            next_st.nlat = st.fp ? 7'h01 : st.count[d] + 7'h01;
        end

        // Second half-cycle: sum update; both operands load the multiplier.
        d = st.dap[PH_SEN2];
        if (st.pipe[PH_SEN2]) begin
            next_st.sum[d] = st.fp ? st.theta : st.sum[d] + st.theta;
            next_st.msum = st.fp ? st.theta : st.sum[d] + st.theta;
            next_st.mrec = recip_rom[st.nlat];
        end

        // Status bits: a set at cycle end wins over a same-cycle clear.
        // A clear that loses leaves the bit set, so the new reply's first sample adds onto the old sum and count.
        for (int i = 0; i < NUM_DEC; i++) begin
            if (protocol_select_in ? (preamble_detect_in && i == int'(MS_ADDRESS))
                                   : bracket_detect_in[i]) begin
                next_st.status[i] = 1'b0;
            end
        end
        if (st.pipe[PH_FOURTH]) begin
            next_st.status[st.dap[PH_FOURTH]] = 1'b1;
        end

        // Average; wraparound modulo a full turn gives the unsigned bearing.
        // The sum is sign extended so that a negative corrected sum still averages
        // to the right bearing once the result is cut to eight bits.
        prod = $signed({{17{st.msum[15]}}, st.msum}) * $signed({16'h0000, st.mrec});
        if (st.pipe[PH_MULT]) begin
            next_st.avg = prod[23:16];
        end
        if (st.pipe[PH_SIXTH]) begin
            next_st.buf1[st.dap[PH_SIXTH]] = {st.count[st.dap[PH_SIXTH]], st.avg};
        end

        // Second buffer and word bus.
        // The ATCRBS copy uses the live reply-done flags, so they must stand while
        // the write strobe is high; a flag dropped early copies another entry.
        if (protocol_select_in) begin
            if (st.pipe[PH_SEVENTH] && st.dap[PH_SEVENTH] == MS_ADDRESS) begin
                next_st.buf2[MS_ADDRESS] = {st.status[MS_ADDRESS], MS_COUNT,
                                            st.buf1[MS_ADDRESS][7:0]};
            end
            if (mode_s_angle_request_in) begin
                next_st.word = st.buf2[MS_ADDRESS];
            end
        end else begin
            for (int i = 0; i < NUM_DEC; i++) begin
                if (reply_done_flag_in[i]) begin
                    id = 2'(i);
                end
            end
            if (buffer_write_strobe_in) begin
                next_st.buf2[write_location_in] = {st.status[id], st.buf1[id]};
            end
            if (angle_read_request_in) begin
                next_st.word = st.buf2[read_location_in];
            end
        end

        // The half indicator feeds no local logic; it is exported for the
        // attached multiplier, which steps on the two-cycle clock.
        // Two-cycle clock is high in the last clock of the first half and the first clock of the second.
        next_st.bc = sample_process_enable || st.pipe[PH_SEN1];
        next_st.half = st.pipe[PH_SEN1] || st.pipe[PH_SEN2];

        // APB: zero-wait slave, data prepared during the setup cycle.
        // Only the enable bit is writable; status and word are read-only views,
        // so a stray write cannot disturb a reply in progress.
        next_st.ready = setup;
        next_st.err = setup && !(paddr_in == ADDR_CTRL || paddr_in == ADDR_STATUS
                                  || paddr_in == ADDR_WORD);
        next_st.rdata = 32'h0000_0000;
        if (setup && !pwrite_in) begin
            case (paddr_in)
                ADDR_CTRL:   next_st.rdata = {31'h0, st.enable};
                ADDR_STATUS: next_st.rdata = {18'h0, st.ms_count, 4'h0, st.status};
                ADDR_WORD:   next_st.rdata = {16'h0, st.word};
                default:     next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (psel_in && penable_in && st.ready && pwrite_in && paddr_in == ADDR_CTRL) begin
            next_st.enable = pwdata_in[0];
        end
    end

    // The reset branch loads constants only; accumulation restarts enabled so
    // samples are counted without any software action.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.enable <= CTRL_RESET; // status bits clear with the rest.
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.rdata;
    assign pready_out = st.ready;
    assign pslverr_out = st.err;
    assign word_out = st.word;
    assign ms_drive_enable_out = st.ms_drive;
    assign sample_process_enable_out = st.ms_sen;
    assign sample_strobe_out = st.ms_stb;
    assign decoder_address_out = st.ms_da;
    assign two_cycle_clock_out = st.bc;
    assign half_select_out = st.half;
    assign first_pulse_flag_out = st.fp;
    assign decoder_sampled_line_out = st.status;

    // Every check below samples on the system clock and rests while reset holds.
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Mode S control.
    a_ms_outputs_quiet: assert property (!ms_drive_enable_out |->
        !sample_process_enable_out && !sample_strobe_out && decoder_address_out == 2'h0)
        else $error("Mode S outputs active outside Mode S");

    a_ms_fixed_address: assert property (ms_drive_enable_out |->
        decoder_address_out == MS_ADDRESS) else $error("Mode S address not fixed");

    a_ms_bit_limit: assert property (sample_strobe_out |-> $past(st.ms_count) < MS_BITS)
        else $error("Mode S strobe beyond first 32 bits");

    a_chip_select: assert property (protocol_select_in && st.ms_count < MS_BITS
        && (mode_s_data_in ? second_chip_strobe_in : first_chip_strobe_in)
        |=> sample_strobe_out) else $error("Chip strobe not passed");

    a_preamble_clear: assert property (preamble_detect_in |=> st.ms_count == 6'h00)
        else $error("Pulse count not cleared");

    a_drive_follows_mode: assert property (
        ms_drive_enable_out == $past(protocol_select_in))
        else $error("Mode S drive does not follow the mode");

    a_strobe_then_enable: assert property (
        sample_strobe_out && protocol_select_in
        |=> sample_process_enable_out)
        else $error("Mode S enable does not follow its strobe");

    // Accumulator stages.
    a_first_count_one: assert property (st.pipe[PH_SEN1] && st.fp
        |=> st.nlat == 7'h01) else $error("First sample count not one");

    a_count_increment: assert property (
        st.pipe[PH_SEN1] && !st.fp
        |=> st.nlat == $past(st.count[st.dap[PH_SEN1]]) + 7'h01)
        else $error("Count not incremented");

    a_status_set_end: assert property (st.pipe[PH_FOURTH] |=>
        decoder_sampled_line_out[$past(st.dap[PH_FOURTH])]) else $error("Status not set");

    a_status_clear_ms: assert property (
        protocol_select_in && preamble_detect_in && !st.pipe[PH_FOURTH]
        |=> !decoder_sampled_line_out[MS_ADDRESS])
        else $error("Mode S status not cleared by preamble");

    a_sum_first_load: assert property (st.pipe[PH_SEN2] && st.fp
        |=> st.msum == $past(st.theta)) else $error("First sum not loaded");

    a_half_pattern: assert property ($rose(half_select_out) |-> ##1 half_select_out
        ##1 !half_select_out) else $error("Half indicator not two cycles");

    a_clock_first_half: assert property (
        st.pipe[PH_SEN1]
        |=> two_cycle_clock_out)
        else $error("Two-cycle clock missing in second half");

    a_half_second: assert property (
        st.pipe[PH_SEN2]
        |=> half_select_out)
        else $error("Half indicator low in second half");

    // Output buffers and word bus.
    a_buf1_update: assert property (
        st.pipe[PH_SIXTH]
        |=> st.buf1[$past(st.dap[PH_SIXTH])][7:0] == $past(st.avg))
        else $error("First buffer not updated");

    a_ms_copy: assert property (
        protocol_select_in && st.pipe[PH_SEVENTH] && st.dap[PH_SEVENTH] == MS_ADDRESS
        |=> st.buf2[MS_ADDRESS][7:0] == $past(st.buf1[MS_ADDRESS][7:0]))
        else $error("Mode S entry not copied");

    a_ms_count_word: assert property (protocol_select_in && mode_s_angle_request_in
        |=> word_out[14:8] == MS_COUNT) else $error("Mode S count not 32");

    a_ms_word_read: assert property (
        protocol_select_in && mode_s_angle_request_in
        |=> word_out == $past(st.buf2[MS_ADDRESS]))
        else $error("Mode S word not driven");

    a_atc_word_read: assert property (
        !protocol_select_in && angle_read_request_in
        |=> word_out == $past(st.buf2[read_location_in]))
        else $error("ATCRBS word not driven");

    a_word_holds: assert property (
        !angle_read_request_in && !mode_s_angle_request_in
        |=> $stable(word_out))
        else $error("Word bus changed without a request");
endmodule : baa_accumulator

// ---- test/baa_reply_model.sv ----
// Reply processor model: sends its own words, then asks for the angle word.
// Assumes the bench hands it one start pulse per transfer, clocked on the system clock.
`timescale 1ns/100ps
module baa_reply_model (
    input  wire logic       clock_in,   // System clock
    input  wire logic       rst_in,     // Reset, active high
    input  wire logic       ms_go_in,   // Start a Mode S nine-word transfer
    input  wire logic       atc_go_in,  // Start an ATCRBS four-word transfer
    input  wire logic [1:0] loc_in,     // Reply buffer location to use
    output logic            ms_req_out, // Mode S angle request
    output logic            rd_req_out, // ATCRBS angle read request
    output logic            wr_out,     // Reply buffer write strobe
    output logic      [1:0] wr_loc_out, // Write location
    output logic      [1:0] rd_loc_out  // Read location
);
    logic [3:0] cnt;
    logic       ms;

    // Locations toggle while not in use, so a design that reads them stale will see junk.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            {cnt, ms, ms_req_out, rd_req_out, wr_out, wr_loc_out, rd_loc_out} <= '0;
        end else begin
            ms_req_out <= 1'b0;
            rd_req_out <= 1'b0;
            wr_out     <= 1'b0;
            wr_loc_out <= ~wr_loc_out;
            rd_loc_out <= ~rd_loc_out;
            if (ms_go_in || atc_go_in) begin
                cnt        <= ms_go_in ? 4'h9 : 4'h4;
                ms         <= ms_go_in;
                wr_out     <= atc_go_in;
                wr_loc_out <= loc_in;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                if (cnt == 4'h1) begin
                    ms_req_out <= ms;
                    rd_req_out <= ~ms;
                    rd_loc_out <= loc_in;
                end
            end
        end
    end
endmodule : baa_reply_model

// ---- test/baa_accumulator_bench.sv ----
// Self-checking bench for the bearing average accumulator.
// Assumes the reply processor model in this folder and the one-cycle APB answer.
`timescale 1ns/100ps
module baa_accumulator_bench;
    import baa_pkg::*;
    logic        clock_in, rst_in, protocol_select_in, first_chip_strobe_in;
    logic        second_chip_strobe_in, mode_s_data_in, preamble_detect_in;
    logic        confidence_strobe_in, atc_sample_enable_in, atc_strobe_in;
    logic        buffer_write_strobe_in, angle_read_request_in, mode_s_angle_request_in;
    logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out, ms_drive_enable_out;
    logic        sample_process_enable_out, sample_strobe_out, two_cycle_clock_out;
    logic        half_select_out, first_pulse_flag_out, ms_go, atc_go, err;
    logic [1:0]  atc_decoder_address_in, write_location_in, read_location_in;
    logic [1:0]  decoder_address_out, loc;
    logic [3:0]  bracket_detect_in, reply_done_flag_in, decoder_sampled_line_out;
    logic [7:0]  angle_sample_in, paddr_in;
    logic [15:0] word_out;
    logic [31:0] pwdata_in, prdata_out, rd;
    int          error_cnt, num_checks, cyc;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, r; logic e;} baa_row_type;
    baa_row_type rows [10] = '{'{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h04, 32'hff, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h00, 32'h1, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}};

    baa_accumulator uut (.clock_in, .rst_in, .protocol_select_in, .first_chip_strobe_in,
        .second_chip_strobe_in, .mode_s_data_in, .preamble_detect_in, .confidence_strobe_in,
        .atc_sample_enable_in, .atc_strobe_in, .atc_decoder_address_in, .angle_sample_in,
        .bracket_detect_in, .reply_done_flag_in, .write_location_in, .read_location_in,
        .buffer_write_strobe_in, .angle_read_request_in, .mode_s_angle_request_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .word_out, .ms_drive_enable_out, .sample_process_enable_out, .sample_strobe_out,
        .decoder_address_out, .two_cycle_clock_out, .half_select_out, .first_pulse_flag_out,
        .decoder_sampled_line_out);
    baa_reply_model model (.clock_in, .rst_in, .ms_go_in(ms_go), .atc_go_in(atc_go),
        .loc_in(loc), .ms_req_out(mode_s_angle_request_in), .rd_req_out(angle_read_request_in),
        .wr_out(buffer_write_strobe_in), .wr_loc_out(write_location_in),
        .rd_loc_out(read_location_in));

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Reads sample the edge that ends the access, before that edge's updates land.
    task automatic apb(input baa_row_type row);
        int n;
        n = 0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, row.w, row.a, row.d};
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clock_in);
    endtask : apb

    task automatic samp(input logic [1:0] dec, input logic [7:0] a);
        angle_sample_in <= a;
        atc_strobe_in <= 1'b1;
        @(posedge clock_in);
        atc_strobe_in <= 1'b0;
        atc_sample_enable_in <= 1'b1;
        atc_decoder_address_in <= dec;
        @(posedge clock_in);
        atc_sample_enable_in <= 1'b0;
        repeat (10) @(posedge clock_in);
    endtask : samp

    task automatic xfer(input logic [1:0] dec);
        reply_done_flag_in <= 4'h1 << dec;
        loc <= ~dec;
        atc_go <= 1'b1;
        @(posedge clock_in);
        atc_go <= 1'b0;
        repeat (8) @(posedge clock_in);
        reply_done_flag_in <= 4'h0;
    endtask : xfer

    task automatic pair(input logic [1:0] dec, input logic [7:0] a, b, input logic [15:0] exp);
        bracket_detect_in <= 4'h1 << dec;
        @(posedge clock_in);
        bracket_detect_in <= 4'h0;
        repeat (2) @(posedge clock_in);
        check(32'(decoder_sampled_line_out[dec]), 32'h0);
        samp(dec, a);
        check(32'(first_pulse_flag_out), 32'h1);
        check(32'(decoder_sampled_line_out[dec]), 32'h1);
        samp(dec, b);
        check(32'(first_pulse_flag_out), 32'h0);
        xfer(dec);
        check(32'(word_out), 32'(exp));
    endtask : pair

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask : tick

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        rst_in = 1'b1;
        {protocol_select_in, first_chip_strobe_in, second_chip_strobe_in, mode_s_data_in,
         preamble_detect_in, confidence_strobe_in, atc_sample_enable_in, atc_strobe_in,
         atc_decoder_address_in, angle_sample_in, bracket_detect_in, reply_done_flag_in,
         psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, ms_go, atc_go, loc} = '0;
        tick(2);
        rst_in <= 1'b0;
        tick(1);
        foreach (rows[i]) begin
            apb(rows[i]);
            if (!rows[i].w) check(rd, rows[i].r);
            check(32'(err), 32'(rows[i].e));
        end
        pair(2'h2, 8'h40, 8'h44, 16'h8242);
        pair(2'h3, 8'hf0, 8'h10, 16'h8200);
        pair(2'h0, 8'h10, 8'hf0, 16'h8200);
        bracket_detect_in <= 4'h2;
        tick(1);
        bracket_detect_in <= 4'h0;
        xfer(2'h1);
        check(32'(word_out[15]), 32'h0);
        protocol_select_in <= 1'b1;
        tick(3);
        check(32'(ms_drive_enable_out), 32'h1);
        check(32'(decoder_address_out), 32'(MS_ADDRESS));
        preamble_detect_in <= 1'b1;
        tick(1);
        preamble_detect_in <= 1'b0;
        tick(2);
        check(32'(decoder_sampled_line_out[1]), 32'h0);
        angle_sample_in <= 8'h30;
        mode_s_data_in <= 1'b1;
        first_chip_strobe_in <= 1'b1;
        tick(1);
        first_chip_strobe_in <= 1'b0;
        tick(1);
        check(32'(sample_strobe_out), 32'h0);
        second_chip_strobe_in <= 1'b1;
        tick(1);
        second_chip_strobe_in <= 1'b0;
        tick(1);
        check(32'(sample_strobe_out), 32'h1);
        for (int i = 0; i < 32; i++) begin
            confidence_strobe_in <= 1'b1;
            tick(1);
            confidence_strobe_in <= 1'b0;
            tick(i == 0 ? 10 : 1);
            if (i == 0) begin
                ms_go <= 1'b1;
                tick(1);
                ms_go <= 1'b0;
                tick(14);
                check(32'(word_out), 32'ha030);
            end
        end
        second_chip_strobe_in <= 1'b1;
        tick(1);
        second_chip_strobe_in <= 1'b0;
        tick(1);
        check(32'(sample_strobe_out), 32'h0);
        protocol_select_in <= 1'b0;
        tick(3);
        check(32'(ms_drive_enable_out), 32'h0);
        check(32'(decoder_address_out), 32'h0);
        final_report();
    end
endmodule : baa_accumulator_bench
